/* pkg/papcr_defines.vh */
/*
 * Offsets, field positions, reset values and timing figures for the PHY
 * analog and power configuration register bank.
 * Assumes a 100 MHz core clock. Each register index becomes a word address
 * (byte address = index * 4) on a 32-bit classic Wishbone bus.
 */
`ifndef PAPCR_DEFINES_VH
`define PAPCR_DEFINES_VH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PAPCR_IDX_LDCLASS      16'h0404
`define PAPCR_IDX_ANTHRESH     16'h040D
`define PAPCR_IDX_DCCORR       16'h0410
`define PAPCR_IDX_AFILT1       16'h0416
`define PAPCR_IDX_AEQ          16'h0418
`define PAPCR_IDX_SUPOVR       16'h041F
`define PAPCR_IDX_SUPSTAT      16'h0421
`define PAPCR_IDX_DEEPSLP      16'h0428

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PAPCR_RST_LDCLASS      16'h0020
`define PAPCR_RST_ANTHRESH     16'h0008
`define PAPCR_RST_DCCORR       16'h2000
`define PAPCR_RST_AFILT1       16'h0870
`define PAPCR_RST_AEQ          16'h0000
`define PAPCR_RST_SUPOVR       16'h0000
`define PAPCR_RST_DEEPSLP      16'h0000

// ----------------------------------------------------------------------------
// field layout and codes
// ----------------------------------------------------------------------------
`define PAPCR_LDCLASS_B        16'h0020
`define PAPCR_LDCLASS_A        16'h0024
`define PAPCR_ANTHRESH_HI      4
`define PAPCR_DCCORR_FIXED     14
`define PAPCR_AFILT1_HI        12
`define PAPCR_AFILT1_LO        8
`define PAPCR_AEQ_HI           13
`define PAPCR_AEQ_LO           8
`define PAPCR_SUPOVR_CORE      12
`define PAPCR_SUPOVR_IO_HI     11
`define PAPCR_SUPOVR_IO_LO     10
`define PAPCR_IO_FORCE         2'h3
`define PAPCR_IO_LEVEL_3V3     2'h3
`define PAPCR_SUPSTAT_CORE     2
`define PAPCR_DEEPSLP_IDLE_MSB 5
`define PAPCR_DEEPSLP_IDLE_EN  4
`define PAPCR_DEEPSLP_FAST     3
`define PAPCR_DEEPSLP_ENABLE   2
`define PAPCR_DEEPSLP_RW_MASK  16'h003F

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define PAPCR_CLK_KHZ          100000
`define PAPCR_EXIT_FAST_MS     50
`define PAPCR_EXIT_SLOW_MS     100
`define PAPCR_EXIT_FAST_CYC    (`PAPCR_EXIT_FAST_MS * `PAPCR_CLK_KHZ)
`define PAPCR_EXIT_SLOW_CYC    (`PAPCR_EXIT_SLOW_MS * `PAPCR_CLK_KHZ)

`endif

/* verilog/papcr_regs.v */
/*
 * PHY analog and power configuration register bank with its control logic:
 * line driver class, energy threshold, DC correction, filter and equalizer
 * trims, supply level overrides, idle test pattern and deep sleep sequencing.
 * Assumes a classic Wishbone master on core_clk, analog detector levels
 * arriving asynchronously, and the standard power-down request and low four
 * idle-pattern bits coming from logic on core_clk.
 */
//
// What this block does
// [RL1] 0x0020 picks class B, 0x0024 class A
// [RL2] five-bit energy threshold, resets to 01000
// [RL3] bit 14 selects fixed DC correction
// [RL4] filter one cut-off field, resets to 01000
// [RL5] six-bit analog equalizer field, resets zero
// [RL6] bit 12 forces core supply to 3.3V
// [RL7] bits 11:10 at 11 force I/O 3.3V
// [RL8] five-bit value gives zeros after each one
// [RL9] zero value clears the pattern gap counter
// [RL10] bit 4 enables the idle test pattern
// [RL11] bit 3 picks 50 ms or 100 ms exit
// [RL12] bit 2 enters and leaves deep power-down
// [RL13] host enters standard power-down before deep sleep
// [RL14] read-only reserved bits ignore writes, read reset
`timescale 1ns/1ps
`default_nettype none
`include "papcr_defines.vh"

module papcr_regs #(
    // 24-bit counts: 167 ms at most
    parameter [23:0] EXIT_FAST_CYCLES = `PAPCR_EXIT_FAST_CYC,
    parameter [23:0] EXIT_SLOW_CYCLES = `PAPCR_EXIT_SLOW_CYC
) (
    input  wire        core_clk,
    input  wire        rst,
    // classic wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [15:0] wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // analog detector levels, power-down sources and idle pattern bits
    input  wire        analog_core_supply_det,
    input  wire [1:0]  io_supply_det,
    input  wire        interrupt_powerdown_pin_n,
    input  wire        std_power_down,
    input  wire [3:0]  idle_pattern_low,
    // controls toward the analog front end
    output reg         line_driver_class_a,
    output reg         line_driver_class_b,
    output reg  [4:0]  energy_threshold,
    output reg         fixed_dc_enable,
    output reg  [4:0]  filter1_cutoff,
    output reg  [5:0]  equalizer_setting,
    output reg         analog_core_supply_3v3,
    output reg  [1:0]  analog_io_supply_level,
    output reg         idle_test_active,
    output reg         idle_test_bit,
    output reg         deep_sleep_active,
    output reg         deep_sleep_exiting
);

    // ------------------------------------------------------------------------
    // state codes
    // ------------------------------------------------------------------------
    localparam [2:0] ST_RUN  = 3'h1;
    localparam [2:0] ST_DEEP = 3'h2;
    localparam [2:0] ST_EXIT = 3'h4;

    // ------------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------------
    reg  [15:0] ldclass_reg;
    reg  [15:0] anthresh_reg;
    reg  [15:0] dccorr_reg;
    reg  [15:0] afilt1_reg;
    reg  [15:0] aeq_reg;
    reg  [15:0] supovr_reg;
    reg  [15:0] deepslp_reg;
    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [23:0] exit_cnt_reg;
    reg  [23:0] exit_cnt_next;
    reg  [4:0]  gap_cnt_reg;
    reg  [1:0]  core_sync_reg;
    reg  [3:0]  io_sync_reg;
    reg  [1:0]  pin_sync_reg;
    reg  [15:0] rd_data;
    reg         addr_hit;

    wire        bus_req;
    wire        wr_stb;
    wire [15:0] wmask;
    wire [4:0]  idle_value;
    wire        core_det;
    wire [1:0]  io_det;
    wire        pd_requested;
    wire [15:0] status_word;

    // request accepted once per cycle; answer one edge later
    // ack high blocks a retake
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_stb  = bus_req & wb_we_i;
    // lanes 3 and 2 unused
    assign wmask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // synchronised outside levels, read only from the second stage
    // pin asks for power-down when low
    assign core_det     = core_sync_reg[1];
    assign io_det       = io_sync_reg[3:2];
    assign pd_requested = std_power_down | ~pin_sync_reg[1];

    // five-bit idle value: bit 5 of deep sleep control on top
    assign idle_value = {deepslp_reg[`PAPCR_DEEPSLP_IDLE_MSB], idle_pattern_low}; // [RL8]

    // status shows the levels the device acts on
    // forced or detected level
    assign status_word = {13'h0000, analog_core_supply_3v3, analog_io_supply_level};

    // ------------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------------
    // two flops on each asynchronous input
    // pin flops reset high, its idle
    // level: no false request
    always @(posedge core_clk) begin
        if (rst) begin
            core_sync_reg <= 2'h0;
            io_sync_reg   <= 4'h0;
            pin_sync_reg  <= 2'h3;
        end else begin
            core_sync_reg <= {core_sync_reg[0], analog_core_supply_det};
            io_sync_reg   <= {io_sync_reg[1:0], io_supply_det};
            pin_sync_reg  <= {pin_sync_reg[0], interrupt_powerdown_pin_n};
        end
    end

    // ------------------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------------------
    // read decode, unmapped words read as zero
    // misaligned words hit nothing
    always @* begin
        rd_data  = 16'h0000;
        addr_hit = 1'b1;
        if (wb_adr_i[1:0] != 2'h0) begin
            addr_hit = 1'b0;
        end else begin
            case ({2'h0, wb_adr_i[15:2]})
                `PAPCR_IDX_LDCLASS:  rd_data = ldclass_reg;
                `PAPCR_IDX_ANTHRESH: rd_data = anthresh_reg;
                `PAPCR_IDX_DCCORR:   rd_data = dccorr_reg;
                `PAPCR_IDX_AFILT1:   rd_data = afilt1_reg;
                `PAPCR_IDX_AEQ:      rd_data = aeq_reg;
                `PAPCR_IDX_SUPOVR:   rd_data = supovr_reg;
                `PAPCR_IDX_SUPSTAT:  rd_data = status_word;
                `PAPCR_IDX_DEEPSLP:  rd_data = deepslp_reg;
                default:             addr_hit = 1'b0;
            endcase
        end
    end

    // one-cycle ack, registered read data
    // read data holds until next read
    always @(posedge core_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= {16'h0000, rd_data};
            end
        end
    end

    // register writes under byte lane masks
    // reserved rw bits keep writes [RL14]
    always @(posedge core_clk) begin
        if (rst) begin
            ldclass_reg  <= `PAPCR_RST_LDCLASS;
            anthresh_reg <= `PAPCR_RST_ANTHRESH;
            dccorr_reg   <= `PAPCR_RST_DCCORR;
            afilt1_reg   <= `PAPCR_RST_AFILT1;
            aeq_reg      <= `PAPCR_RST_AEQ;
            supovr_reg   <= `PAPCR_RST_SUPOVR;
            deepslp_reg  <= `PAPCR_RST_DEEPSLP;
        end else if (wr_stb && addr_hit) begin
            case ({2'h0, wb_adr_i[15:2]})
                `PAPCR_IDX_LDCLASS: begin
                    ldclass_reg <= (ldclass_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
                end
                `PAPCR_IDX_ANTHRESH: begin
                    anthresh_reg <= (anthresh_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
                end
                `PAPCR_IDX_DCCORR: begin
                    dccorr_reg <= (dccorr_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
                end
                `PAPCR_IDX_AFILT1: begin
                    afilt1_reg <= (afilt1_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
                end
                `PAPCR_IDX_AEQ: begin
                    aeq_reg <= (aeq_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
                end
                `PAPCR_IDX_SUPOVR: begin
                    supovr_reg <= (supovr_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
                end
                `PAPCR_IDX_DEEPSLP: begin
                    // upper bits stay zero whatever is written [RL14]
                    deepslp_reg <= ((deepslp_reg & ~wmask) | (wb_dat_i[15:0] & wmask))
                                   & `PAPCR_DEEPSLP_RW_MASK;
                end
                default: begin
                    // status word is read-only [RL14]
                    deepslp_reg <= deepslp_reg;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // analog trims and supply selection
    // ------------------------------------------------------------------------
    // registered copies of the trim fields and decoded selections
    // outputs lag the register a clock
    always @(posedge core_clk) begin
        if (rst) begin
            line_driver_class_a    <= 1'b0;
            line_driver_class_b    <= 1'b1;
            energy_threshold       <= 5'h08;
            fixed_dc_enable        <= 1'b0;
            filter1_cutoff         <= 5'h08;
            equalizer_setting      <= 6'h00;
            analog_core_supply_3v3 <= 1'b0;
            analog_io_supply_level <= 2'h0;
        end else begin
            line_driver_class_a <= (ldclass_reg == `PAPCR_LDCLASS_A); // [RL1]
            line_driver_class_b <= (ldclass_reg == `PAPCR_LDCLASS_B); // [RL1]
            energy_threshold    <= anthresh_reg[`PAPCR_ANTHRESH_HI:0]; // [RL2]
            fixed_dc_enable     <= dccorr_reg[`PAPCR_DCCORR_FIXED]; // [RL3]
            filter1_cutoff      <= afilt1_reg[`PAPCR_AFILT1_HI:`PAPCR_AFILT1_LO]; // [RL4]
            equalizer_setting   <= aeq_reg[`PAPCR_AEQ_HI:`PAPCR_AEQ_LO]; // [RL5]
            // forced 3.3V or the detector's decision
            analog_core_supply_3v3 <= supovr_reg[`PAPCR_SUPOVR_CORE] | core_det; // [RL6]
            if (supovr_reg[`PAPCR_SUPOVR_IO_HI:`PAPCR_SUPOVR_IO_LO] == `PAPCR_IO_FORCE) begin
                analog_io_supply_level <= `PAPCR_IO_LEVEL_3V3; // [RL7]
            end else begin
                analog_io_supply_level <= io_det; // [RL7]
            end
        end
    end

    // ------------------------------------------------------------------------
    // idle test pattern
    // ------------------------------------------------------------------------
    // a one, then idle_value zeros, repeated; zero value holds the line low
    // reload on a one only, so a new
    // non-zero value never cuts a gap short
    always @(posedge core_clk) begin
        if (rst) begin
            idle_test_active <= 1'b0;
            idle_test_bit    <= 1'b0;
            gap_cnt_reg      <= 5'h00;
        end else begin
            idle_test_active <= deepslp_reg[`PAPCR_DEEPSLP_IDLE_EN]; // [RL10]
            if (!deepslp_reg[`PAPCR_DEEPSLP_IDLE_EN] || idle_value == 5'h00) begin
                idle_test_bit <= 1'b0; // [RL9]
                gap_cnt_reg   <= 5'h00;
            end else if (gap_cnt_reg == 5'h00) begin
                idle_test_bit <= 1'b1; // [RL8]
                gap_cnt_reg   <= idle_value;
            end else begin
                idle_test_bit <= 1'b0; // [RL8]
                gap_cnt_reg   <= gap_cnt_reg - 5'h01;
            end
        end
    end

    // ------------------------------------------------------------------------
    // deep sleep sequencing
    // ------------------------------------------------------------------------
    // next state: enter on standard or pin power-down request, timed exit
    always @* begin
        state_next    = state_reg;
        exit_cnt_next = exit_cnt_reg;
        case (state_reg)
            ST_RUN: begin
                // waits for power-down
                if (deepslp_reg[`PAPCR_DEEPSLP_ENABLE] && pd_requested) begin
                    state_next = ST_DEEP; // [RL12] [RL13]
                end
            end
            ST_DEEP: begin
                if (!deepslp_reg[`PAPCR_DEEPSLP_ENABLE]) begin
                    // one short: full count
                    state_next = ST_EXIT; // [RL12]
                    if (deepslp_reg[`PAPCR_DEEPSLP_FAST]) begin
                        exit_cnt_next = EXIT_FAST_CYCLES - 24'h000001; // [RL11]
                    end else begin
                        exit_cnt_next = EXIT_SLOW_CYCLES - 24'h000001; // [RL11]
                    end
                end
            end
            ST_EXIT: begin
                if (exit_cnt_reg == 24'h000000) begin
                    state_next = ST_RUN;
                end else begin
                    exit_cnt_next = exit_cnt_reg - 24'h000001;
                end
            end
            default: begin
                // illegal code: back to run
                state_next    = ST_RUN;
                exit_cnt_next = 24'h000000;
            end
        endcase
    end

    // state flops and registered status outputs
    // outputs decode the next state,
    // so they move with it
    always @(posedge core_clk) begin
        if (rst) begin
            state_reg          <= ST_RUN;
            exit_cnt_reg       <= 24'h000000;
            deep_sleep_active  <= 1'b0;
            deep_sleep_exiting <= 1'b0;
        end else begin
            state_reg          <= state_next;
            exit_cnt_reg       <= exit_cnt_next;
            deep_sleep_active  <= (state_next == ST_DEEP);
            deep_sleep_exiting <= (state_next == ST_EXIT);
        end
    end

endmodule

`default_nettype wire

/* verif/papcr_monitor.sv */
/* checker for the analog power register bank.
   assumes a bind onto papcr_regs with one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module papcr_monitor #(
    parameter [23:0] EXIT_SLOW_CYCLES = 24'h000028
) (
    input wire        core_clk,
    input wire        rst,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [15:0] wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        line_driver_class_a,
    input wire        line_driver_class_b,
    input wire [4:0]  energy_threshold,
    input wire        fixed_dc_enable,
    input wire [4:0]  filter1_cutoff,
    input wire [5:0]  equalizer_setting,
    input wire        idle_test_active,
    input wire        idle_test_bit,
    input wire        deep_sleep_exiting
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    reg  [23:0] exit_run_reg;
    wire        take_cls;
    // full write taken on the class register
    assign take_cls = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
                      && wb_adr_i == 16'h1010 && wb_sel_i[1:0] == 2'h3;
    // length of the current exit run
    always @(posedge core_clk) begin
        if (rst || !deep_sleep_exiting) exit_run_reg <= 24'h000000;
        else exit_run_reg <= exit_run_reg + 24'h000001;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    chk_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_no_req: assert property (!wb_cyc_i |=> !wb_ack_o)
        else $error("ack without request");
    chk_rdata_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read data not zero");
    chk_class_b_sel: assert property (take_cls && wb_dat_i[15:0] == 16'h0020
        |=> ##[1:2] line_driver_class_b && !line_driver_class_a)
        else $error("class b not selected");
    chk_class_a_sel: assert property (take_cls && wb_dat_i[15:0] == 16'h0024
        |=> ##[1:2] line_driver_class_a && !line_driver_class_b)
        else $error("class a not selected");
    chk_class_exclusive: assert property (!(line_driver_class_a && line_driver_class_b))
        else $error("both driver classes active");
    chk_reset_fields: assert property ($fell(rst) |->
        energy_threshold == 5'h08 && filter1_cutoff == 5'h08
        && !fixed_dc_enable && equalizer_setting == 6'h00)
        else $error("trim outputs wrong after reset");
    chk_idle_zero_gap: assert property (idle_test_bit |=> !idle_test_bit)
        else $error("idle one not followed by zero");
    chk_idle_off_quiet: assert property (!idle_test_active [*2] |-> !idle_test_bit)
        else $error("idle bit while test off");
    chk_exit_run_bound: assert property (exit_run_reg <= EXIT_SLOW_CYCLES + 24'h000001)
        else $error("exit lasts too long");
    cover property (line_driver_class_a);
    cover property ($rose(deep_sleep_exiting));
    cover property (idle_test_bit);
endmodule
bind papcr_regs papcr_monitor #(.EXIT_SLOW_CYCLES(EXIT_SLOW_CYCLES)) papcr_monitor_i (
    .core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .line_driver_class_a, .line_driver_class_b, .energy_threshold,
    .fixed_dc_enable, .filter1_cutoff, .equalizer_setting, .idle_test_active,
    .idle_test_bit, .deep_sleep_exiting);
`default_nettype wire

/* verif/papcr_regs_tb.sv */
/* self-checking bench for the analog power register bank.
   assumes papcr_regs with shortened exit counts and a wishbone bus. */
`timescale 1ns/1ps
`default_nettype none
module papcr_regs_tb;
    localparam integer FAST = 20;
    localparam integer SLOW = 40;
    logic core_clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [15:0] wb_adr_i = 16'h0000;
    logic [3:0]  wb_sel_i = 4'h0, idle_pattern_low = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic analog_core_supply_det = 1'b0, interrupt_powerdown_pin_n = 1'b1, std_power_down = 1'b0;
    logic [1:0]  io_supply_det = 2'h0;
    wire  [31:0] wb_dat_o;
    wire  [4:0]  energy_threshold, filter1_cutoff;
    wire  [5:0]  equalizer_setting;
    wire  [1:0]  analog_io_supply_level;
    wire wb_ack_o, line_driver_class_a, line_driver_class_b, fixed_dc_enable;
    wire analog_core_supply_3v3, idle_test_active, idle_test_bit;
    wire deep_sleep_active, deep_sleep_exiting;
    integer fails = 0, n_checks = 0, g;
    papcr_regs #(.EXIT_FAST_CYCLES(FAST), .EXIT_SLOW_CYCLES(SLOW)) papcr_regs_i (
        .core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .analog_core_supply_det, .io_supply_det,
        .interrupt_powerdown_pin_n, .std_power_down, .idle_pattern_low,
        .line_driver_class_a, .line_driver_class_b, .energy_threshold, .fixed_dc_enable,
        .filter1_cutoff, .equalizer_setting, .analog_core_supply_3v3,
        .analog_io_supply_level, .idle_test_active, .idle_test_bit, .deep_sleep_active,
        .deep_sleep_exiting);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial forever #5 core_clk = ~core_clk;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks = n_checks + 1;
        if (s !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, s);
            fails = fails + 1;
        end
    endtask
    task automatic tick(input integer k);
        repeat (k) @(posedge core_clk);
    endtask
    // one classic cycle, held until ack is sampled
    task automatic xfer(input logic w, input logic [15:0] idx, input logic [15:0] d,
                        output logic [31:0] rd);
        integer n;
        n = 0;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= {idx[13:0], 2'h0};
        wb_sel_i <= 4'hF;
        wb_dat_i <= {16'h0000, d};
        @(posedge core_clk);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            n = n + 1;
        end
        chk("ack", 32'h1, 32'(wb_ack_o));
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        logic [31:0] x;
        xfer(1'b1, idx, d, x);
        tick(2);
    endtask
    task automatic rdc(input logic [15:0] idx, input logic [31:0] e, input string nm);
        logic [31:0] x;
        xfer(1'b0, idx, 16'h0000, x);
        chk(nm, e, x);
    endtask
    // zeros between two ones of the idle stream
    task automatic gap(output integer n);
        integer k;
        n = 0;
        for (k = 0; k < 200 && idle_test_bit !== 1'b1; k++) @(posedge core_clk);
        @(posedge core_clk);
        while (idle_test_bit === 1'b0 && n < 100) begin
            n = n + 1;
            @(posedge core_clk);
        end
    endtask
    // length of one exit run
    task automatic run(output integer n);
        integer k;
        n = 0;
        for (k = 0; k < 20 && deep_sleep_exiting !== 1'b1; k++) @(posedge core_clk);
        while (deep_sleep_exiting === 1'b1 && n < 100) begin
            n = n + 1;
            @(posedge core_clk);
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rdc(16'h0404, 32'h0020, "class reg");
        rdc(16'h040D, 32'h0008, "thresh reg");
        rdc(16'h0410, 32'h2000, "dc reg");
        rdc(16'h0416, 32'h0870, "filter reg");
        rdc(16'h0418, 32'h0000, "eq reg");
        rdc(16'h041F, 32'h0000, "override reg");
        rdc(16'h0428, 32'h0000, "sleep reg");
        rdc(16'h0405, 32'h0000, "unmapped");
        chk("threshold", 32'h08, 32'(energy_threshold));
    endtask
    task automatic t_class;
        wr(16'h0404, 16'h0024);
        chk("class a", 32'h2, 32'({line_driver_class_a, line_driver_class_b}));
        wr(16'h0404, 16'h0005);
        chk("class none", 32'h0, 32'({line_driver_class_a, line_driver_class_b}));
        wr(16'h0404, 16'h0020);
        chk("class b", 32'h1, 32'({line_driver_class_a, line_driver_class_b}));
    endtask
    task automatic t_trims;
        wr(16'h040D, 16'hFFFF);
        wr(16'h0410, 16'hFFFF);
        wr(16'h0416, 16'hFFFF);
        wr(16'h0418, 16'hFFFF);
        chk("threshold", 32'h1F, 32'(energy_threshold));
        chk("fixed dc", 32'h1, 32'(fixed_dc_enable));
        chk("cutoff", 32'h1F, 32'(filter1_cutoff));
        chk("equalizer", 32'h3F, 32'(equalizer_setting));
        rdc(16'h0416, 32'hFFFF, "filter reg");
        @(posedge core_clk);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(2);
        chk("cutoff rst", 32'h08, 32'(filter1_cutoff));
        chk("eq rst", 32'h00, 32'({fixed_dc_enable, equalizer_setting}));
    endtask
    task automatic t_supply;
        rdc(16'h0421, 32'h0000, "status");
        wr(16'h041F, 16'h1C00);
        chk("forced", 32'h7, 32'({analog_core_supply_3v3, analog_io_supply_level}));
        wr(16'h0421, 16'h0000);
        rdc(16'h0421, 32'h0007, "status ro");
        wr(16'h041F, 16'h0800);
        chk("detect", 32'h0, 32'({analog_core_supply_3v3, analog_io_supply_level}));
        analog_core_supply_det <= 1'b1;
        io_supply_det <= 2'h1;
        tick(5);
        chk("det", 32'h5, 32'({analog_core_supply_3v3, analog_io_supply_level}));
    endtask
    task automatic t_idle;
        idle_pattern_low <= 4'h2;
        wr(16'h0428, 16'h0010);
        chk("idle on", 32'h1, 32'(idle_test_active));
        gap(g);
        gap(g);
        chk("gap 2", 32'd2, 32'(g));
        wr(16'h0428, 16'h0030);
        gap(g);
        gap(g);
        chk("gap 18", 32'd18, 32'(g));
        idle_pattern_low <= 4'h0;
        wr(16'h0428, 16'h0010);
        gap(g);
        chk("idle zero", 32'h0, 32'(idle_test_bit));
        wr(16'h0428, 16'h0000);
    endtask
    task automatic t_deep;
        std_power_down <= 1'b1;
        tick(4);
        chk("no entry", 32'h0, 32'(deep_sleep_active));
        wr(16'h0428, 16'h0004);
        chk("entry", 32'h1, 32'(deep_sleep_active));
        wr(16'h0428, 16'h0008);
        run(g);
        chk("fast exit", 32'h1, 32'(g >= FAST - 1 && g <= FAST + 1));
        chk("awake", 32'h0, 32'({deep_sleep_active, deep_sleep_exiting}));
        std_power_down <= 1'b0;
        interrupt_powerdown_pin_n <= 1'b0;
        wr(16'h0428, 16'h0004);
        tick(5);
        chk("pin entry", 32'h1, 32'(deep_sleep_active));
        wr(16'h0428, 16'h0000);
        run(g);
        chk("slow exit", 32'h1, 32'(g >= SLOW - 1 && g <= SLOW + 1));
        interrupt_powerdown_pin_n <= 1'b1;
        wr(16'h0428, 16'hFFFB);
        rdc(16'h0428, 32'h003B, "sleep ro");
        wr(16'h0428, 16'h0000);
    endtask
    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #300000;
        fails = fails + 1;
        summarize;
    end
    initial begin
        tick(12);
        rst <= 1'b0;
        tick(4);
        t_reset;
        t_class;
        t_trims;
        t_supply;
        t_idle;
        t_deep;
        summarize;
    end
endmodule
`default_nettype wire
